// [pkg/pin_if_pkg.sv]
package pin_if_pkg;
	// oscillator cycles per plain bus cycle and per phase
	localparam int unsigned OSC_PER_BUS = 4;
	localparam int unsigned HIGH_CYCLES = 2;
	localparam int unsigned STRETCH_CYCLES = 4;
	localparam logic [1:0] STRETCH_LAST = 2'(STRETCH_CYCLES - 1);

	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_PORT_A_DATA = 14'h1000;
	localparam logic [13:0] IDX_PORT_A_DIR = 14'h1001;
	localparam logic [13:0] IDX_PORT_G_DATA = 14'h1002;
	localparam logic [13:0] IDX_PORT_G_DIR = 14'h1003;
	localparam logic [13:0] IDX_PORT_B_DATA = 14'h1004;
	localparam logic [13:0] IDX_PORT_F_DATA = 14'h1005;
	localparam logic [13:0] IDX_PORT_C_DATA = 14'h1006;
	localparam logic [13:0] IDX_PORT_C_DIR = 14'h1007;
	localparam logic [13:0] IDX_PORT_D_DATA = 14'h1008;
	localparam logic [13:0] IDX_PORT_D_DIR = 14'h1009;
	localparam logic [13:0] IDX_PORT_E_DATA = 14'h100a;

	// values after reset
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [5:0] PORT_D_RESET = 6'h00;
	localparam logic [1:0] MODE_RESET = 2'h2;

	// operating modes as {mode_select_b, mode_select_a}
	localparam logic [1:0] MODE_BOOT = 2'h0;
	localparam logic [1:0] MODE_TEST = 2'h1;
	localparam logic [1:0] MODE_SINGLE = 2'h2;
	localparam logic [1:0] MODE_EXPANDED = 2'h3;

	typedef enum logic [2:0] {
		PH_LOW0 = 3'b000,
		PH_LOW1 = 3'b001,
		PH_HIGH0 = 3'b010,
		PH_HIGH1 = 3'b011,
		PH_STRETCH = 3'b100
	} bus_phase_e;
endpackage

// [src/expanded_bus_pin_interface.sv]
`timescale 1ns/1ps
// Contract
// - reset pin low returns all logic but the reset pin drive to start
// - monitor or watchdog failure pulls reset pin low
// - bus clock is oscillator divided by four
// - address while bus clock low, data while high; ports B and F show the address only from the bus clock rise
// - strobe pin is inverse of bus clock
// - stretch input sampled at bus clock rise
// - stretch high holds bus clock four more cycles
// - stretch low lets clock fall after two
// - interrupt pin may fall at any time
// - second interrupt non-maskable once X cleared
// - mode pins held during reset, latched then
// - first mode pin later pulses instruction start
// - expanded and test modes drive read/write pin
// - port A leaves reset as inputs
// - port B outputs data or upper address
// - port C is GPIO or data bus
// - port F outputs data or lower address
// - port D lines GPIO or serial unit
// - chip selects replace port G upper pins
module expanded_bus_pin_interface
	import pin_if_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic clock_fail,
	input wire logic watchdog_fail,
	output logic bus_clock,
	output logic bus_strobe_n,
	input wire logic bus_wait,
	input wire logic irq_n,
	input wire logic nonmask_int_n,
	input wire logic x_flag,
	output logic irq_req,
	output logic nonmask_req,
	input wire logic mode_select_a_in,
	input wire logic mode_select_b,
	output logic instruction_start_out,
	output logic instruction_start_oe,
	input wire logic insn_start,
	output logic expanded,
	output logic rw_out,
	output logic rw_oe,
	input wire logic ext_req,
	input wire logic ext_write,
	input wire logic [15:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	output logic ext_done,
	input wire logic [7:0] gpio_a_in,
	output logic [7:0] gpio_a_out,
	output logic [7:0] gpio_a_oe,
	output logic [7:0] out_b_pins,
	input wire logic [7:0] gpio_c_in,
	output logic [7:0] gpio_c_out,
	output logic [7:0] gpio_c_oe,
	input wire logic [5:0] gpio_d_in,
	output logic [5:0] gpio_d_out,
	output logic [5:0] gpio_d_oe,
	input wire logic [5:0] serial_own,
	input wire logic [5:0] serial_out,
	input wire logic [5:0] serial_oe,
	input wire logic [7:0] port_e_in,
	output logic [7:0] out_f_pins,
	input wire logic [7:0] gpio_g_in,
	output logic [7:0] gpio_g_out,
	output logic [7:0] gpio_g_oe,
	input wire logic cs_enable,
	input wire logic [3:0] cs_lines
);
	// the reset pin acts as a second, pin-level reset
	logic rst_all;
	assign rst_all = sys_rst | ~reset_pin_in;

	// software registers
	logic [7:0] port_a, dir_a, port_g, dir_g, port_b, port_f, port_c, dir_c;
	logic [5:0] port_d, dir_d;
	logic [7:0] next_port_a, next_dir_a, next_port_g, next_dir_g;
	logic [7:0] next_port_b, next_port_f, next_port_c, next_dir_c;
	logic [5:0] next_port_d, next_dir_d;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [13:0] idx;
	logic hit, commit;
	logic [7:0] rd_byte;

	// bus engine state
	bus_phase_e state, next_state;
	logic [1:0] stretch_cnt, next_stretch_cnt;
	logic wait_seen, next_wait_seen;
	logic [1:0] mode, next_mode;
	logic active, next_active, xwrite, next_xwrite;
	logic [15:0] xaddr, next_xaddr;
	logic [7:0] xdata, next_xdata, next_ext_rdata;
	logic next_ext_done, cycle_end, high_next;
	logic lir_pend, next_lir_pend, next_lir_oe;
	logic is_exp;

	// interrupt synchronisers
	logic irq_s1, irq_s2, nmi_s1, nmi_s2;

	// pin outputs, next values
	logic next_rst_oe;
	logic [7:0] next_a_out, next_a_oe, next_b, next_c_out, next_c_oe, next_f;
	logic [7:0] next_g_out, next_g_oe;
	logic [5:0] next_d_out, next_d_oe;
	logic next_rw, next_rw_oe;

	// test mode runs the external bus as well
	assign is_exp = (mode == MODE_EXPANDED) || (mode == MODE_TEST);

	// apb decode; one wait state keeps pready on a flop
	assign idx = paddr[15:2];
	assign commit = psel & penable & pready;
	always_comb begin
		hit = (paddr[1:0] == 2'h0);
		rd_byte = 8'h00;
		case (idx)
			IDX_PORT_A_DATA: rd_byte = (dir_a & port_a) | (~dir_a & gpio_a_in);
			IDX_PORT_A_DIR: rd_byte = dir_a;
			IDX_PORT_G_DATA: rd_byte = (dir_g & port_g) | (~dir_g & gpio_g_in);
			IDX_PORT_G_DIR: rd_byte = dir_g;
			IDX_PORT_B_DATA: rd_byte = port_b;
			IDX_PORT_F_DATA: rd_byte = port_f;
			IDX_PORT_C_DATA: rd_byte = (dir_c & port_c) | (~dir_c & gpio_c_in);
			IDX_PORT_C_DIR: rd_byte = dir_c;
			IDX_PORT_D_DATA: rd_byte = {2'h0, (dir_d & port_d) | (~dir_d & gpio_d_in)};
			IDX_PORT_D_DIR: rd_byte = {2'h0, dir_d};
			IDX_PORT_E_DATA: rd_byte = port_e_in;
			default: hit = 1'b0;
		endcase
	end

	// register writes and read answer
	always_comb begin
		next_pready = psel & penable & ~pready;
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (psel & penable & ~pready) begin
			next_prdata = {24'h0, pwrite ? 8'h00 : rd_byte};
			next_pslverr = ~hit;
		end
		next_port_a = port_a;
		next_dir_a = dir_a;
		next_port_g = port_g;
		next_dir_g = dir_g;
		next_port_b = port_b;
		next_port_f = port_f;
		next_port_c = port_c;
		next_dir_c = dir_c;
		next_port_d = port_d;
		next_dir_d = dir_d;
		if (commit && pwrite && hit) begin
			case (idx)
				IDX_PORT_A_DATA: next_port_a = pwdata[7:0];
				IDX_PORT_A_DIR: next_dir_a = pwdata[7:0];
				IDX_PORT_G_DATA: next_port_g = pwdata[7:0];
				IDX_PORT_G_DIR: next_dir_g = pwdata[7:0];
				IDX_PORT_B_DATA: next_port_b = pwdata[7:0];
				IDX_PORT_F_DATA: next_port_f = pwdata[7:0];
				IDX_PORT_C_DATA: next_port_c = pwdata[7:0];
				IDX_PORT_C_DIR: next_dir_c = pwdata[7:0];
				IDX_PORT_D_DATA: next_port_d = pwdata[5:0];
				IDX_PORT_D_DIR: next_dir_d = pwdata[5:0];
				default: next_port_a = port_a;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst_all) begin
			port_a <= PORT_RESET;
			dir_a <= PORT_RESET;
			port_g <= PORT_RESET;
			dir_g <= PORT_RESET;
			port_b <= PORT_RESET;
			port_f <= PORT_RESET;
			port_c <= PORT_RESET;
			dir_c <= PORT_RESET;
			port_d <= PORT_D_RESET;
			dir_d <= PORT_D_RESET;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			port_a <= next_port_a;
			dir_a <= next_dir_a;
			port_g <= next_port_g;
			dir_g <= next_dir_g;
			port_b <= next_port_b;
			port_f <= next_port_f;
			port_c <= next_port_c;
			dir_c <= next_dir_c;
			port_d <= next_port_d;
			dir_d <= next_dir_d;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// bus clock sequencer: two low, two high, plus four when stretched
	always_comb begin
		next_state = state;
		next_stretch_cnt = stretch_cnt;
		next_wait_seen = wait_seen;
		cycle_end = 1'b0;
		case (state)
			PH_LOW0: next_state = PH_LOW1;
			PH_LOW1: begin
				next_state = PH_HIGH0;
				next_wait_seen = bus_wait;
			end
			PH_HIGH0: next_state = PH_HIGH1;
			PH_HIGH1: begin
				if (wait_seen) begin
					next_state = PH_STRETCH;
					next_stretch_cnt = STRETCH_LAST;
				end else begin
					next_state = PH_LOW0;
					cycle_end = 1'b1;
				end
			end
			PH_STRETCH: begin
				if (stretch_cnt == 2'h0) begin
					next_state = PH_LOW0;
					cycle_end = 1'b1;
				end else begin
					next_stretch_cnt = stretch_cnt - 2'h1;
				end
			end
			default: next_state = PH_LOW0;
		endcase
		high_next = (next_state == PH_HIGH0) || (next_state == PH_HIGH1) ||
			(next_state == PH_STRETCH);
	end

	// external transfer: taken at the first low phase, held to cycle end
	always_comb begin
		next_mode = rst_all ? {mode_select_b, mode_select_a_in} : mode;
		next_active = active;
		next_xwrite = xwrite;
		next_xaddr = xaddr;
		next_xdata = xdata;
		next_ext_rdata = ext_rdata;
		next_ext_done = 1'b0;
		if (state == PH_LOW0) begin
			// ext_done still high means the master has not yet let go
			next_active = ext_req & ~ext_done & is_exp;
			if (ext_req & ~ext_done & is_exp) begin
				next_xwrite = ext_write;
				next_xaddr = ext_addr;
				next_xdata = ext_wdata;
			end
		end
		if (cycle_end && active) begin
			next_active = 1'b0;
			next_ext_done = 1'b1;
			if (!xwrite) begin
				next_ext_rdata = gpio_c_in;
			end
		end
		// set wins over the take so no instruction start is lost
		next_lir_pend = lir_pend;
		next_lir_oe = instruction_start_oe;
		if (state == PH_LOW0) begin
			next_lir_oe = lir_pend;
			next_lir_pend = 1'b0;
		end
		if (insn_start) begin
			next_lir_pend = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst_all) begin
			state <= PH_LOW0;
			stretch_cnt <= 2'h0;
			wait_seen <= 1'b0;
			active <= 1'b0;
			xwrite <= 1'b0;
			xaddr <= 16'h0000;
			xdata <= 8'h00;
			ext_rdata <= 8'h00;
			ext_done <= 1'b0;
			lir_pend <= 1'b0;
			instruction_start_oe <= 1'b0;
			bus_clock <= 1'b0;
			bus_strobe_n <= 1'b1;
		end else begin
			state <= next_state;
			stretch_cnt <= next_stretch_cnt;
			wait_seen <= next_wait_seen;
			active <= next_active;
			xwrite <= next_xwrite;
			xaddr <= next_xaddr;
			xdata <= next_xdata;
			ext_rdata <= next_ext_rdata;
			ext_done <= next_ext_done;
			lir_pend <= next_lir_pend;
			instruction_start_oe <= next_lir_oe;
			bus_clock <= high_next;
			bus_strobe_n <= ~high_next;
		end
		mode <= next_mode; // strap caught while reset is held
		instruction_start_out <= 1'b0; // open drain only pulls low
	end

	// pin steering by mode
	always_comb begin
		next_rst_oe = clock_fail | watchdog_fail;
		next_a_out = port_a;
		next_a_oe = dir_a;
		next_b = is_exp ? xaddr[15:8] : port_b;
		next_f = is_exp ? xaddr[7:0] : port_f;
		next_c_out = is_exp ? xdata : port_c;
		next_c_oe = is_exp ? {8{active & xwrite & high_next}} : dir_c;
		next_rw = ~(active & xwrite);
		next_rw_oe = is_exp;
		next_g_out = port_g;
		next_g_oe = dir_g;
		if (cs_enable) begin
			next_g_out[7:4] = cs_lines;
			next_g_oe[7:4] = 4'hf;
		end
	end

	// port d hands each line to the serial unit bit by bit
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_port_d
			assign next_d_out[gi] = serial_own[gi] ? serial_out[gi] : port_d[gi];
			assign next_d_oe[gi] = serial_own[gi] ? serial_oe[gi] : dir_d[gi];
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reset_pin_oe <= 1'b0;
		end else begin
			reset_pin_oe <= next_rst_oe;
		end
		reset_pin_out <= 1'b0;
		if (rst_all) begin
			gpio_a_out <= PORT_RESET;
			gpio_a_oe <= PORT_RESET;
			out_b_pins <= PORT_RESET;
			out_f_pins <= PORT_RESET;
			gpio_c_out <= PORT_RESET;
			gpio_c_oe <= PORT_RESET;
			gpio_d_out <= PORT_D_RESET;
			gpio_d_oe <= PORT_D_RESET;
			gpio_g_out <= PORT_RESET;
			gpio_g_oe <= PORT_RESET;
			rw_out <= 1'b1;
			rw_oe <= 1'b0;
			expanded <= 1'b0;
		end else begin
			gpio_a_out <= next_a_out;
			gpio_a_oe <= next_a_oe;
			out_b_pins <= next_b;
			out_f_pins <= next_f;
			gpio_c_out <= next_c_out;
			gpio_c_oe <= next_c_oe;
			gpio_d_out <= next_d_out;
			gpio_d_oe <= next_d_oe;
			gpio_g_out <= next_g_out;
			gpio_g_oe <= next_g_oe;
			rw_out <= next_rw;
			rw_oe <= next_rw_oe;
			expanded <= is_exp;
		end
	end

	// interrupt pins are asynchronous, so two flops before use
	always_ff @(posedge clock) begin
		if (rst_all) begin
			irq_s1 <= 1'b1;
			irq_s2 <= 1'b1;
			nmi_s1 <= 1'b1;
			nmi_s2 <= 1'b1;
			irq_req <= 1'b0;
			nonmask_req <= 1'b0;
		end else begin
			irq_s1 <= irq_n;
			irq_s2 <= irq_s1;
			nmi_s1 <= nonmask_int_n;
			nmi_s2 <= nmi_s1;
			irq_req <= ~irq_s2;
			nonmask_req <= ~nmi_s2 & ~x_flag;
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking

	sequence s_rise_plain;
		$rose(bus_clock) && !wait_seen;
	endsequence
	sequence s_rise_stretch;
		$rose(bus_clock) && wait_seen;
	endsequence

	a_normal_fall: assert property (disable iff (rst_all)
		s_rise_plain |-> bus_clock ##1 bus_clock ##1 !bus_clock ##1 !bus_clock ##1 bus_clock)
		else $error("plain bus cycle not four oscillator cycles");
	a_stretch_len: assert property (disable iff (rst_all)
		s_rise_stretch |-> bus_clock [*6] ##1 !bus_clock)
		else $error("stretched high phase not six cycles");
	a_wait_sample: assert property (disable iff (rst_all)
		$rose(bus_clock) |-> wait_seen == $past(bus_wait))
		else $error("stretch input not sampled at bus clock rise");
	a_strobe_inverse: assert property (disable iff (rst_all)
		bus_strobe_n == !bus_clock)
		else $error("strobe not inverse of bus clock");
	a_data_high: assert property (disable iff (rst_all)
		(expanded && gpio_c_oe != 8'h00) |-> bus_clock)
		else $error("data bus driven while bus clock low");
	a_addr_stable: assert property (disable iff (rst_all)
		(expanded && bus_clock && $past(bus_clock)) |->
		$stable(out_f_pins) && $stable(out_b_pins) && $stable(rw_out))
		else $error("address or direction moved in high phase");
	a_addr_upper: assert property (disable iff (rst_all)
		(!$past(rst_all) && is_exp && $past(is_exp)) |-> out_b_pins == $past(xaddr[15:8]))
		else $error("port b not showing upper address");
	a_reset_drive: assert property (disable iff (sys_rst)
		(clock_fail || watchdog_fail) |=> reset_pin_oe && !reset_pin_out)
		else $error("failure did not pull reset pin low");
	a_port_a_reset: assert property (disable iff (sys_rst)
		rst_all |=> gpio_a_oe == 8'h00)
		else $error("port a driven after reset");
	a_rw_mode: assert property (disable iff (rst_all)
		(!$past(rst_all) && $past(is_exp)) |-> rw_oe)
		else $error("read/write pin not driven in expanded mode");
	a_cs_pins: assert property (disable iff (rst_all)
		cs_enable |=> gpio_g_oe[7:4] == 4'hf && gpio_g_out[7:4] == $past(cs_lines))
		else $error("chip selects not on port g");
	a_nonmask: assert property (disable iff (rst_all)
		nonmask_req |-> !$past(x_flag))
		else $error("non-maskable request while X set");
endmodule

// [verif/ext_mem_model.sv]
`timescale 1ns/1ps
// behavioural byte memory on the external bus, aliased on the low address nibble
module ext_mem_model (
	input wire logic clock,
	input wire logic bus_clock,
	input wire logic rw_out,
	input wire logic [15:0] addr,
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_oe,
	input wire logic slow,
	output logic [7:0] data_in,
	output logic bus_wait
);
	logic [7:0] mem [16];
	logic [7:0] junk = 8'h5a;

	// a slow device asks for a stretch at every rise
	assign bus_wait = slow;
	// read data only in the high phase; a toggling pattern otherwise, so the last byte read returns every other cycle
	assign data_in = (bus_clock && rw_out) ? mem[addr[3:0]] : junk;

	// capture the byte while the device drives the data bus
	always @(posedge clock) begin
		junk <= ~data_in;
		if (bus_clock && !rw_out && data_oe == 8'hff) begin
			mem[addr[3:0]] <= data_out;
		end
	end
endmodule

// [verif/expanded_bus_pin_interface_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module expanded_bus_pin_interface_tb_top;
	import pin_if_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] paddr = 16'h0000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, pin_rst_n = 1'b1;
	logic [31:0] pwdata = 32'h0;
	logic clock_fail = 1'b0, watchdog_fail = 1'b0, irq_n = 1'b1, nonmask_int_n = 1'b1;
	logic x_flag = 1'b1, mode_select_a_in = 1'b0, mode_select_b = 1'b1, insn_start = 1'b0;
	logic ext_req = 1'b0, ext_write = 1'b0, cs_enable = 1'b0;
	logic [15:0] ext_addr = 16'h0;
	logic [7:0] ext_wdata = 8'h0, gpio_a_in = 8'h0, port_e_in = 8'h96, gpio_g_in = 8'h0;
	logic [5:0] gpio_d_in = 6'h0, serial_own = 6'h0, serial_out = 6'h0, serial_oe = 6'h0;
	logic [3:0] cs_lines = 4'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, reset_pin_out, reset_pin_oe, bus_clock, bus_strobe_n, bus_wait, er;
	logic irq_req, nonmask_req, instruction_start_out, instruction_start_oe, expanded;
	logic rw_out, rw_oe, ext_done, reset_pin_in;
	logic [7:0] ext_rdata, gpio_a_out, gpio_a_oe, out_b_pins, gpio_c_out, gpio_c_oe, gpio_c_in;
	logic [7:0] out_f_pins, gpio_g_out, gpio_g_oe;
	logic [5:0] gpio_d_out, gpio_d_oe;
	logic [16:0] prev_pins;
	int error_cnt = 0, n_tests = 0, cyc = 0, hi_cnt = 0, lo_cnt = 0, last_hi = 0, last_lo = 0, k;

	always #4 clock = ~clock;
	// open-drain reset wire with pull-up
	assign reset_pin_in = pin_rst_n & ~(reset_pin_oe & ~reset_pin_out);

	expanded_bus_pin_interface uut (.clock, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .clock_fail,
		.watchdog_fail, .bus_clock, .bus_strobe_n, .bus_wait, .irq_n, .nonmask_int_n, .x_flag,
		.irq_req, .nonmask_req, .mode_select_a_in, .mode_select_b, .instruction_start_out,
		.instruction_start_oe, .insn_start, .expanded, .rw_out, .rw_oe, .ext_req, .ext_write,
		.ext_addr, .ext_wdata, .ext_rdata, .ext_done, .gpio_a_in, .gpio_a_out, .gpio_a_oe,
		.out_b_pins, .gpio_c_in, .gpio_c_out, .gpio_c_oe, .gpio_d_in, .gpio_d_out, .gpio_d_oe,
		.serial_own, .serial_out, .serial_oe, .port_e_in, .out_f_pins, .gpio_g_in, .gpio_g_out,
		.gpio_g_oe, .cs_enable, .cs_lines);

	ext_mem_model mem (.clock, .bus_clock, .rw_out, .addr({out_b_pins, out_f_pins}),
		.data_out(gpio_c_out), .data_oe(gpio_c_oe), .slow, .data_in(gpio_c_in), .bus_wait);

	task summarize();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; waits for pready, giving up after 20 cycles
	task apb(input logic w, input logic [13:0] idx, input logic [1:0] lo, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, lo};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, 2'h0, {24'h0, d});
		// register lands at the commit edge, the pin flop one edge later
		repeat (2) @(posedge clock);
	endtask

	task rchk(input string nm, input logic [13:0] idx, input logic [7:0] ex);
		apb(1'b0, idx, 2'h0, 32'h0);
		`CHK(nm, {24'h0, ex}, rd)
	endtask

	// the first strap moves right after release: the latched mode must not follow it
	task do_reset(input logic [1:0] m);
		@(posedge clock);
		sys_rst <= 1'b1;
		{mode_select_b, mode_select_a_in} <= m;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		mode_select_a_in <= ~m[0];
		// mode outputs are flopped once more after release
		@(posedge clock);
	endtask

	// one external bus cycle; keeps the pins seen in the last high sample
	task ext(input logic w, input logic [15:0] a, input logic [7:0] d);
		int t;
		logic [16:0] seen;
		t = 0;
		@(posedge clock);
		ext_req <= 1'b1;
		ext_write <= w;
		ext_addr <= a;
		ext_wdata <= d;
		do begin
			@(posedge clock);
			t++;
			if (bus_clock === 1'b1) seen = {out_b_pins, out_f_pins, rw_out};
		end while (ext_done !== 1'b1 && t < 40);
		rd = {24'h0, ext_rdata};
		ext_req <= 1'b0;
		`CHK("bus pins", {a, ~w}, seen)
		@(posedge clock);
	endtask

	// wire watch, phase lengths and hang limit
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
		if (cyc > 3) begin
			`CHK("strobe", ~bus_clock, bus_strobe_n)
			if (expanded === 1'b1 && bus_clock === 1'b0) `CHK("data drive", 8'h00, gpio_c_oe)
		end
		if (bus_clock === 1'b1) begin
			if (hi_cnt != 0 && ext_req === 1'b1)
				`CHK("held pins", prev_pins, {out_b_pins, out_f_pins, rw_out})
			hi_cnt <= hi_cnt + 1;
			lo_cnt <= 0;
			if (lo_cnt != 0) last_lo <= lo_cnt;
		end else begin
			lo_cnt <= lo_cnt + 1;
			hi_cnt <= 0;
			if (hi_cnt != 0) last_hi <= hi_cnt;
		end
		prev_pins <= {out_b_pins, out_f_pins, rw_out};
	end

	// main sequence: single-chip ports first, then modes, then the external bus
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		`CHK("port a oe", 8'h00, gpio_a_oe)
		rchk("port a dir", IDX_PORT_A_DIR, PORT_RESET);
		gpio_a_in <= 8'h3c;
		wr(IDX_PORT_A_DIR, 8'hf0);
		wr(IDX_PORT_A_DATA, 8'haa);
		rchk("port a pins", IDX_PORT_A_DATA, 8'hac);
		`CHK("port a oe", 8'hf0, gpio_a_oe)
		wr(IDX_PORT_B_DATA, 8'ha5);
		wr(IDX_PORT_F_DATA, 8'h3c);
		`CHK("port b", 8'ha5, out_b_pins)
		`CHK("port f", 8'h3c, out_f_pins)
		wr(IDX_PORT_C_DIR, 8'hff);
		wr(IDX_PORT_C_DATA, 8'h5a);
		`CHK("port c out", 8'h5a, gpio_c_out)
		`CHK("port c oe", 8'hff, gpio_c_oe)
		serial_own <= 6'h30;
		serial_out <= 6'h20;
		serial_oe <= 6'h30;
		wr(IDX_PORT_D_DIR, 8'h3f);
		wr(IDX_PORT_D_DATA, 8'h15);
		`CHK("port d out", 6'h25, gpio_d_out)
		`CHK("port d oe", 6'h3f, gpio_d_oe)
		cs_enable <= 1'b1;
		cs_lines <= 4'ha;
		wr(IDX_PORT_G_DIR, 8'hff);
		`CHK("chip selects", 4'ha, gpio_g_out[7:4])
		rchk("port e", IDX_PORT_E_DATA, 8'h96);
		wr(IDX_PORT_E_DATA, 8'h00);
		rchk("port e", IDX_PORT_E_DATA, 8'h96);
		apb(1'b0, 14'h100c, 2'h0, 32'h0);
		`CHK("unmapped", 33'h100000000, {er, rd})
		apb(1'b1, IDX_PORT_B_DATA, 2'h1, 32'hff);
		`CHK("misaligned", 1'b1, er)
		`CHK("port b kept", 8'ha5, out_b_pins)
		for (int i = 0; i < 2; i++) begin
			wr(IDX_PORT_B_DATA, 8'ha5);
			{clock_fail, watchdog_fail} <= i[0] ? 2'b10 : 2'b01;
			// the pin is pulled only while the failure stands
			repeat (2) @(posedge clock);
			`CHK("reset drive", 2'b10, {reset_pin_oe, reset_pin_out})
			{clock_fail, watchdog_fail} <= 2'b00;
			repeat (3) @(posedge clock);
			`CHK("port b reset", PORT_RESET, out_b_pins)
			do_reset(MODE_SINGLE);
		end
		irq_n <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK("irq", 1'b1, irq_req)
		irq_n <= 1'b1;
		nonmask_int_n <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK("irq off", 1'b0, irq_req)
		`CHK("nmi masked", 1'b0, nonmask_req)
		x_flag <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("nmi", 1'b1, nonmask_req)
		nonmask_int_n <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1:0]);
			`CHK("mode", m[0], expanded)
			`CHK("rw drive", m[0], rw_oe)
		end
		repeat (2) @(posedge clock);
		`CHK("mode held", 1'b1, expanded)
		ext(1'b1, 16'h12a5, 8'h3c);
		ext(1'b0, 16'h12a5, 8'h00);
		`CHK("ext read", 32'h3c, rd)
		`CHK("high phase", 2, last_hi)
		`CHK("bus period", 4, last_hi + last_lo)
		slow <= 1'b1;
		ext(1'b0, 16'h12a5, 8'h00);
		slow <= 1'b0;
		`CHK("slow read", 32'h3c, rd)
		`CHK("stretched high", 6, last_hi)
		insn_start <= 1'b1;
		@(posedge clock);
		insn_start <= 1'b0;
		k = 0;
		repeat (16) begin
			@(posedge clock);
			if (instruction_start_oe === 1'b1) k++;
		end
		`CHK("insn pulse", 4, k)
		`CHK("insn level", 1'b0, instruction_start_out)
		summarize();
	end
endmodule
